//--- bench/test_dti_top.sv
// self-checking testbench for the dual timer block
`timescale 1ns/10ps
module test_dti_top
	import dti_pkg::*;
	;
	// ****************************************************************
	// strobe indexes and bench constants
	// ****************************************************************
	localparam int C_AL = 0;
	localparam int C_AH = 1;
	localparam int C_AM = 2;
	localparam int C_BL = 3;
	localparam int C_BH = 4;
	localparam int C_BM = 5;
	localparam int C_IE = 6;
	localparam int C_HE = 7;
	localparam int C_CLR = 8;
	localparam int C_GEN = 9;
	localparam int C_GDIS = 10;
	localparam int C_TAKE = 11;
	localparam int C_HOLD = 12;
	localparam int C_RET = 13;
	// sub clock is far faster than real so the run stays short
	localparam int SUB_HALF = 8;

	logic clk = 1'b0;
	logic rst = 1'b1;
	logic [7:0] data = 8'h00;
	logic [13:0] stb = 14'h0;
	logic sub = 1'b0;
	logic wave = 1'b0;
	logic [7:0] a_cnt;
	logic [7:0] b_cnt;
	logic [7:0] flags;
	logic [7:0] vec;
	logic a_run;
	logic b_run;
	logic irq;
	logic hold;
	logic tone;
	int failures = 0;
	int checked = 0;
	int cyc = 0;
	int t_run = 0;
	int t_tone = 0;
	int skip = 0;
	bit tmon = 1'b0;
	logic p_run;
	logic p_fa;
	logic p_irq;
	logic p_tone;
	int qa[$];
	int qb[$];
	logic [7:0] qv[$];
	logic [7:0] v;
	logic w;
	int r;

	dti_top u_dti_top (
		.I_CLK(clk),
		.I_RST(rst),
		.I_DATA(data),
		.I_WR_A_LOAD_LOW(stb[C_AL]),
		.I_WR_A_LOAD_HIGH(stb[C_AH]),
		.I_WR_A_MODE(stb[C_AM]),
		.I_WR_B_RELOAD_LOW(stb[C_BL]),
		.I_WR_B_RELOAD_HIGH(stb[C_BH]),
		.I_WR_B_MODE(stb[C_BM]),
		.I_WR_IRQ_ENABLE(stb[C_IE]),
		.I_WR_HOLD_ENABLE(stb[C_HE]),
		.I_CLR_EVENTS(stb[C_CLR]),
		.I_GLOBAL_ENABLE(stb[C_GEN]),
		.I_GLOBAL_DISABLE(stb[C_GDIS]),
		.I_IRQ_TAKE(stb[C_TAKE]),
		.I_HOLD_ENTER(stb[C_HOLD]),
		.I_RETURN(stb[C_RET]),
		.I_SUB_OSC_CLOCK(sub),
		.I_TONE_WAVE(wave),
		.O_TIMER_A_COUNT(a_cnt),
		.O_TIMER_B_COUNT(b_cnt),
		.O_EVENT_FLAGS(flags),
		.O_TIMER_A_RUN(a_run),
		.O_TIMER_B_RUN(b_run),
		.O_IRQ_REQ(irq),
		.O_IRQ_VECTOR(vec),
		.O_HOLD(hold),
		.O_TONE(tone)
	);

	initial
	forever #(CLK_PERIOD_NS / 2) clk = ~clk;

	initial
	forever
	begin
		repeat (SUB_HALF) @(posedge clk);
		sub <= ~sub;
	end

	// ****************************************************************
	// reporting and compares
	// ****************************************************************
	task tally_and_finish();
		$display("compares %0d, mismatches %0d", checked, failures);
		if (failures == 0 && checked > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask : tally_and_finish

	task miss(input string m);
		failures++;
		$display("CHECK FAILED at %0t: %s", $time, m);
	endtask : miss

	task chk8(input logic [7:0] g, input logic [7:0] e, input string m);
		checked++;
		if (g !== e)
			miss($sformatf("%s got %h exp %h", m, g, e));
	endtask : chk8

	task chk1(input logic g, input logic e, input string m);
		checked++;
		if (g !== e)
			miss($sformatf("%s got %b exp %b", m, g, e));
	endtask : chk1

	task chki(input int g, input int e, input string m);
		checked++;
		if (g != e)
			miss($sformatf("%s got %0d exp %0d", m, g, e));
	endtask : chki

	initial
	begin
		repeat (100000) @(posedge clk);
		miss("run limit");
		tally_and_finish();
	end

	// ****************************************************************
	// result watcher
	// ****************************************************************
	always @(negedge clk)
	begin
		cyc++;
		if (a_run === 1'b1 && p_run !== 1'b1)
			t_run = cyc;
		if (flags[EVT_A] === 1'b1 && p_fa !== 1'b1)
		begin
			if (qa.size() == 0)
				miss("stray timer a event");
			else
				chki(cyc - t_run, qa.pop_front(), "a interval");
		end
		if (irq === 1'b1 && p_irq !== 1'b1)
		begin
			if (qv.size() == 0)
				miss("stray interrupt");
			else
				chk8(vec, qv.pop_front(), "vector");
		end
		if (tmon && tone !== p_tone)
		begin
			if (skip == 0 && qb.size() != 0)
				chki(cyc - t_tone, qb.pop_front(), "tone period");
			if (skip > 0)
				skip--;
			t_tone = cyc;
		end
		p_run = a_run;
		p_fa = flags[EVT_A];
		p_irq = irq;
		p_tone = tone;
	end

	// ****************************************************************
	// drivers
	// ****************************************************************
	task cmd(input int k, input logic [7:0] d);
		@(posedge clk);
		data <= d;
		stb <= 14'(1) << k;
		@(posedge clk);
		stb <= 14'h0;
		@(negedge clk);
	endtask : cmd

	task wait_empty();
		int n;
		n = 0;
		while (qa.size() + qb.size() + qv.size() != 0)
		begin
			@(negedge clk);
			n++;
			if (n > 8000)
			begin
				miss("wait limit");
				tally_and_finish();
			end
		end
	endtask : wait_empty

	task run_a(input logic [7:0] ld, input logic s);
		cmd(C_AL, {4'h0, ld[3:0]});
		cmd(C_AH, {4'h0, ld[7:4]});
		chk8(a_cnt, ld, "a load");
		chk1(a_run, 1'b0, "a run after load");
		qa.push_back((int'(ld) + 1) * (s ? A_DIV_SLOW : A_DIV_FAST));
		cmd(C_AM, {4'h0, 1'b1, 2'($urandom), s});
		chk1(flags[EVT_A], 1'b0, "a flag at start");
		wait_empty();
		chk8(a_cnt, COUNT_ALL_ONES, "a end count");
		chk1(a_run, 1'b0, "a stopped");
	endtask : run_a

	task b_tone(input logic [7:0] rl, input logic [7:0] m, input int per);
		tmon = 1'b0;
		cmd(C_BL, {4'h0, rl[3:0]});
		chk1(b_run, 1'b0, "b run after load");
		cmd(C_BH, {4'h0, rl[7:4]});
		// route change may add one edge before the first underflow
		skip = 2;
		repeat (3) qb.push_back(per);
		tmon = 1'b1;
		cmd(C_BM, m);
		chk8(b_cnt, rl, "b reload");
		chk1(flags[EVT_B], 1'b0, "b flag at start");
		wait_empty();
	endtask : b_tone

	// ****************************************************************
	// main sequence
	// ****************************************************************
	initial
	begin
		void'($urandom(94416));
		repeat (6) @(posedge clk);
		rst <= 1'b0;
		@(negedge clk);
		chk8(flags, FLAGS_RESET, "reset flags");
		chk8(a_cnt | b_cnt | vec, 8'h00, "reset counts");
		chk8({a_run, b_run, irq, hold, tone, 3'h0}, 8'h00, "reset");
		repeat (4) run_a(8'($urandom_range(0, 40)), 1'b0);
		run_a(8'h00, 1'b1);
		run_a(8'h01, 1'b1);
		cmd(C_AL, 8'h00);
		cmd(C_AH, 8'h04);
		cmd(C_AM, 8'h08);
		repeat (20) @(negedge clk);
		cmd(C_AM, 8'h00);
		v = a_cnt;
		chk1(v > 8'h38 && v < 8'h40, 1'b1, "a decrement");
		repeat (40) @(negedge clk);
		chk8(a_cnt, v, "a held");
		qa.push_back((int'(v) + 1) * A_DIV_FAST);
		cmd(C_AM, 8'h08);
		wait_empty();
		// clear strobe lands on the underflow edge, flag must survive
		cmd(C_AL, 8'h00);
		cmd(C_AH, 8'h00);
		qa.push_back(A_DIV_FAST);
		cmd(C_AM, 8'h08);
		repeat (A_DIV_FAST - 2) @(negedge clk);
		cmd(C_CLR, 8'h02);
		chk1(flags[EVT_A], 1'b1, "set wins");
		r = $urandom_range(16, 200);
		b_tone(8'(r), 8'h0c, r + 1);
		r = $urandom_range(1, 15);
		b_tone(8'(r), 8'h0d, (r + 1) * B_DIV_SLOW);
		b_tone(8'(r), 8'h0e, (r + 1) * 2 * SUB_HALF);
		qv.push_back(VEC_TIMER_B);
		cmd(C_IE, 8'h80);
		chk1(irq, 1'b1, "b irq");
		cmd(C_BL, 8'h00);
		chk1(b_run, 1'b0, "b stop");
		cmd(C_TAKE, 8'h00);
		chk1(flags[EVT_B], 1'b0, "b take flag");
		chk1(irq, 1'b0, "b take irq");
		cmd(C_CLR, 8'h82);
		chk8(flags, FLAGS_RESET, "clear");
		tmon = 1'b0;
		cmd(C_BM, 8'h00);
		repeat (6)
		begin
			w = 1'($urandom);
			@(posedge clk);
			wave <= w;
			repeat (2) @(posedge clk);
			@(negedge clk);
			chk1(tone, w, "wave route");
		end
		cmd(C_IE, 8'h00);
		run_a(8'h00, 1'b0);
		chk1(irq, 1'b0, "masked");
		qv.push_back(VEC_TIMER_A);
		cmd(C_IE, 8'h02);
		chk1(irq, 1'b1, "a irq");
		cmd(C_TAKE, 8'h00);
		chk1(flags[EVT_A], 1'b0, "a take flag");
		run_a(8'h00, 1'b0);
		chk1(irq, 1'b0, "blocked");
		qv.push_back(VEC_TIMER_A);
		cmd(C_GEN, 8'h00);
		chk1(irq, 1'b1, "global enable");
		cmd(C_GDIS, 8'h00);
		chk1(irq, 1'b0, "global disable");
		qv.push_back(VEC_TIMER_A);
		cmd(C_IE, 8'h02);
		chk1(irq, 1'b1, "rewrite enable");
		cmd(C_CLR, 8'h02);
		chk1(irq, 1'b0, "clear drops irq");
		cmd(C_IE, 8'h00);
		cmd(C_HE, 8'h02);
		cmd(C_HOLD, 8'h00);
		chk1(hold, 1'b1, "hold entered");
		run_a(8'h03, 1'b0);
		// hold state leaves one edge after the flag is seen
		@(negedge clk);
		chk1(hold, 1'b0, "hold released");
		cmd(C_CLR, 8'h02);
		cmd(C_HE, 8'h00);
		cmd(C_HOLD, 8'h00);
		qv.push_back(VEC_TIMER_A);
		cmd(C_IE, 8'h02);
		run_a(8'h00, 1'b0);
		chk1(hold, 1'b1, "hold with irq");
		cmd(C_TAKE, 8'h00);
		chk1(hold, 1'b0, "service");
		cmd(C_RET, 8'h00);
		chk1(hold, 1'b1, "back to hold");
		tally_and_finish();
	end
endmodule : test_dti_top

//--- rtl/dti_pkg.sv
// constants and types shared by the dual timer block
package dti_pkg;
	// ****************************************************************
	// timing
	// ****************************************************************
	localparam int CLK_PERIOD_NS = 100;
	localparam int A_DIV_FAST = 4;
	localparam int A_DIV_SLOW = 1024;
	localparam int B_DIV_SLOW = 64;
	localparam int PRE_A_W = $clog2(A_DIV_SLOW);
	localparam int PRE_B_W = $clog2(B_DIV_SLOW);
	localparam logic [PRE_A_W-1:0] PRE_A_FAST_LAST = PRE_A_W'(A_DIV_FAST - 1);
	localparam logic [PRE_A_W-1:0] PRE_A_SLOW_LAST = PRE_A_W'(A_DIV_SLOW - 1);
	localparam logic [PRE_B_W-1:0] PRE_B_SLOW_LAST = PRE_B_W'(B_DIV_SLOW - 1);

	// ****************************************************************
	// mode register fields (bits 1 and 2 timer b only)
	// ****************************************************************
	localparam int MODE_CLK_SEL = 0;
	localparam int MODE_SRC_SEL = 1;
	localparam int MODE_ROUTE = 2;
	localparam int MODE_RUN = 3;
	localparam logic [3:0] MODE_RESET = 4'h0;

	// ****************************************************************
	// event, interrupt enable and hold release enable bit positions
	// ****************************************************************
	localparam int EVT_A = 1;
	localparam int EVT_B = 7;
	localparam logic [7:0] FLAGS_RESET = 8'h00;
	localparam logic [7:0] COUNT_RESET = 8'h00;
	localparam logic [7:0] COUNT_ALL_ONES = 8'hff;

	// ****************************************************************
	// interrupt vectors, program memory range 004H..023H
	// ****************************************************************
	localparam logic [7:0] VEC_TIMER_A = 8'h08;
	localparam logic [7:0] VEC_TIMER_B = 8'h20;
	localparam logic [7:0] VEC_NONE = 8'h00;

	// ****************************************************************
	// hold mode states
	// ****************************************************************
	typedef enum logic [2:0] {
		ST_RUN = 3'b001,
		ST_HOLD = 3'b010,
		ST_SVC = 3'b100
	} dti_hold_t;
endpackage : dti_pkg

//--- rtl/dti_prescale.sv
// prescalers producing timer a and timer b count enables
`timescale 1ns/10ps
module dti_prescale
	import dti_pkg::*;
(
	// clock and reset
	input wire logic i_clk,
	input wire logic i_rst,
	// tick carrier
	dti_tick_if.pre tk
);
	logic [PRE_A_W-1:0] pre_a;
	logic [PRE_B_W-1:0] pre_b;

	// ****************************************************************
	// timer a prescaler
	// ****************************************************************
	// held at zero while stopped so a start always sees a full period
	always_ff @(posedge i_clk)
	begin
		if (i_rst || !tk.run_a)
			pre_a <= '0;
		else
			pre_a <= pre_a + 1'b1;
	end

	assign tk.tick_a = tk.run_a && (tk.sel_a ? (pre_a == PRE_A_SLOW_LAST)
		: (pre_a[1:0] == PRE_A_FAST_LAST[1:0]));

	// ****************************************************************
	// timer b prescaler
	// ****************************************************************
	always_ff @(posedge i_clk)
	begin
		if (i_rst || !tk.run_b || tk.src_b)
			pre_b <= '0;
		else
			pre_b <= pre_b + 1'b1;
	end

	assign tk.tick_b = tk.run_b && (tk.src_b ? tk.sub_tick
		: (!tk.sel_b || pre_b == PRE_B_SLOW_LAST));
endmodule : dti_prescale

//--- rtl/dti_tick_if.sv
// timer tick carrier between core and prescaler
`timescale 1ns/10ps
interface dti_tick_if;
	logic run_a;
	logic sel_a;
	logic run_b;
	logic sel_b;
	logic src_b;
	logic sub_tick;
	logic tick_a;
	logic tick_b;
	modport core (output run_a, sel_a, run_b, sel_b, src_b, sub_tick,
		input tick_a, tick_b);
	modport pre (input run_a, sel_a, run_b, sel_b, src_b, sub_tick,
		output tick_a, tick_b);
endinterface : dti_tick_if

//--- rtl/dti_top.sv
// dual 8-bit down timer with event, interrupt and hold gating
`timescale 1ns/10ps
// What this block does
// - Timer a counts down by one per selected tick while running.
// - Writing either load nibble of timer a stops it and loads the counter.
// - Setting timer a run bit clears its event flag and starts counting.
// - Timer a underflow to all ones stops it and sets its event flag.
// - Timer a event raises interrupt if enabled, ends hold if enabled.
// - Timer a mode bit 0 picks clock/4 or clock/1024; clock/4 after reset.
// - Timer a mode bit 3 is run; bits 1 and 2 reserved.
// - Timer a interval is (load plus one) times prescale in clock periods.
// - Timer b clock is clock, clock/64 or sub clock; clock after reset.
// - Writing either reload nibble of timer b stores it, clears run.
// - Setting timer b run copies reload, starts counting, clears event.
// - Timer b underflow sets event, reloads and keeps counting.
// - Timer b event raises interrupt if bit 7 enabled, ends hold likewise.
// - Timer b mode bit 0 picks internal clock or clock/64.
// - Timer b mode bit 1 picks internal prescaled clock or sub clock.
// - Timer b mode bit 2 routes tone wave or timer b onto tone pin.
// - Tone pin toggles on each timer b underflow when routed.
// - Interrupt only when an event flag meets its enable bit.
// - Taking an interrupt clears its flag, blocks until enable or rewrite.
// - Global disable blocks all interrupt requests.
// - Vectors lie in program memory 004H through 023H.
// - Interrupt in hold leaves briefly, returns to hold after routine.
// - Flags set by hardware, cleared by software clear, timer start or interrupt take.
module dti_top
	import dti_pkg::*;
(
	// clock and reset
	input wire logic I_CLK,
	input wire logic I_RST,
	// instruction strobes, nibble data on I_DATA[3:0], enable and clear bits on I_DATA[1] and I_DATA[7]
	input wire logic [7:0] I_DATA,
	input wire logic I_WR_A_LOAD_LOW,
	input wire logic I_WR_A_LOAD_HIGH,
	input wire logic I_WR_A_MODE,
	input wire logic I_WR_B_RELOAD_LOW,
	input wire logic I_WR_B_RELOAD_HIGH,
	input wire logic I_WR_B_MODE,
	input wire logic I_WR_IRQ_ENABLE,
	input wire logic I_WR_HOLD_ENABLE,
	input wire logic I_CLR_EVENTS,
	input wire logic I_GLOBAL_ENABLE,
	input wire logic I_GLOBAL_DISABLE,
	// cpu sequencing
	input wire logic I_IRQ_TAKE,
	input wire logic I_HOLD_ENTER,
	input wire logic I_RETURN,
	// external clocks and waveform
	input wire logic I_SUB_OSC_CLOCK,
	input wire logic I_TONE_WAVE,
	// status
	output logic [7:0] O_TIMER_A_COUNT,
	output logic [7:0] O_TIMER_B_COUNT,
	output logic [7:0] O_EVENT_FLAGS,
	output logic O_TIMER_A_RUN,
	output logic O_TIMER_B_RUN,
	// interrupt and hold
	output logic O_IRQ_REQ,
	output logic [7:0] O_IRQ_VECTOR,
	output logic O_HOLD,
	// tone output pin
	output logic O_TONE
);
	dti_tick_if tk ();

	logic [7:0] cnt_a;
	logic [7:0] cnt_b;
	logic [7:0] reload_b;
	logic run_a;
	logic run_b;
	logic sel_a;
	logic sel_b;
	logic src_b;
	logic route_b;
	logic evf_a;
	logic evf_b;
	logic ief_a;
	logic ief_b;
	logic hef_a;
	logic hef_b;
	logic irq_block;
	logic tone_q;
	logic tone_pin;
	logic sub_s1;
	logic sub_s2;
	logic sub_s3;
	dti_hold_t hold_st;
	dti_hold_t next_hold_st;

	logic wr_a_load;
	logic wr_b_load;
	logic start_a;
	logic start_b;
	logic uf_a;
	logic uf_b;
	logic pend_a;
	logic pend_b;
	logic take_a;
	logic take_b;
	logic release_hold;

	// ****************************************************************
	// sub oscillator synchroniser and edge
	// ****************************************************************
	always_ff @(posedge I_CLK)
	begin
		if (I_RST)
		begin
			sub_s1 <= 1'b0;
			sub_s2 <= 1'b0;
			sub_s3 <= 1'b0;
		end
		else
		begin
			sub_s1 <= I_SUB_OSC_CLOCK;
			sub_s2 <= sub_s1;
			sub_s3 <= sub_s2;
		end
	end

	assign tk.sub_tick = sub_s2 && !sub_s3;
	assign tk.run_a = run_a;
	assign tk.sel_a = sel_a;
	assign tk.run_b = run_b;
	assign tk.sel_b = sel_b;
	assign tk.src_b = src_b;

	dti_prescale u_pre (
		.i_clk (I_CLK),
		.i_rst (I_RST),
		.tk (tk)
	);

	// ****************************************************************
	// decode
	// ****************************************************************
	assign wr_a_load = I_WR_A_LOAD_LOW || I_WR_A_LOAD_HIGH;
	assign wr_b_load = I_WR_B_RELOAD_LOW || I_WR_B_RELOAD_HIGH;
	assign start_a = I_WR_A_MODE && I_DATA[MODE_RUN];
	assign start_b = I_WR_B_MODE && I_DATA[MODE_RUN];
	// writes take priority over a tick landing in the same cycle
	assign uf_a = run_a && tk.tick_a && cnt_a == COUNT_RESET
		&& !wr_a_load && !I_WR_A_MODE;
	assign uf_b = run_b && tk.tick_b && cnt_b == COUNT_RESET
		&& !wr_b_load && !I_WR_B_MODE;

	// ****************************************************************
	// timer a
	// ****************************************************************
	always_ff @(posedge I_CLK)
	begin
		if (I_RST)
		begin
			cnt_a <= COUNT_RESET;
			run_a <= MODE_RESET[MODE_RUN];
			sel_a <= MODE_RESET[MODE_CLK_SEL];
		end
		else if (wr_a_load)
		begin
			run_a <= 1'b0;
			if (I_WR_A_LOAD_LOW)
				cnt_a[3:0] <= I_DATA[3:0];
			if (I_WR_A_LOAD_HIGH)
				cnt_a[7:4] <= I_DATA[3:0];
		end
		else if (I_WR_A_MODE)
		begin
			// reserved bits 1 and 2 are ignored
			sel_a <= I_DATA[MODE_CLK_SEL];
			run_a <= I_DATA[MODE_RUN];
		end
		else if (uf_a)
		begin
			cnt_a <= COUNT_ALL_ONES;
			run_a <= 1'b0;
		end
		else if (run_a && tk.tick_a)
			cnt_a <= cnt_a - 1'b1;
	end

	// ****************************************************************
	// timer b
	// ****************************************************************
	always_ff @(posedge I_CLK)
	begin
		if (I_RST)
		begin
			cnt_b <= COUNT_RESET;
			reload_b <= COUNT_RESET;
			run_b <= MODE_RESET[MODE_RUN];
			sel_b <= MODE_RESET[MODE_CLK_SEL];
			src_b <= MODE_RESET[MODE_SRC_SEL];
			route_b <= MODE_RESET[MODE_ROUTE];
		end
		else if (wr_b_load)
		begin
			run_b <= 1'b0;
			if (I_WR_B_RELOAD_LOW)
				reload_b[3:0] <= I_DATA[3:0];
			if (I_WR_B_RELOAD_HIGH)
				reload_b[7:4] <= I_DATA[3:0];
		end
		else if (I_WR_B_MODE)
		begin
			sel_b <= I_DATA[MODE_CLK_SEL];
			src_b <= I_DATA[MODE_SRC_SEL];
			route_b <= I_DATA[MODE_ROUTE];
			run_b <= I_DATA[MODE_RUN];
			if (I_DATA[MODE_RUN])
				cnt_b <= reload_b;
		end
		else if (uf_b)
			cnt_b <= reload_b;
		else if (run_b && tk.tick_b)
			cnt_b <= cnt_b - 1'b1;
	end

	// ****************************************************************
	// tone output
	// ****************************************************************
	always_ff @(posedge I_CLK)
	begin
		if (I_RST)
		begin
			tone_q <= 1'b0;
			tone_pin <= 1'b0;
		end
		else
		begin
			if (uf_b)
				tone_q <= !tone_q;
			tone_pin <= route_b ? tone_q : I_TONE_WAVE;
		end
	end

	// ****************************************************************
	// event flags
	// ****************************************************************
	always_ff @(posedge I_CLK)
	begin
		if (I_RST)
		begin
			evf_a <= FLAGS_RESET[EVT_A];
			evf_b <= FLAGS_RESET[EVT_B];
		end
		else
		begin
			if (uf_a)
				evf_a <= 1'b1;
			else if (start_a || take_a
				|| (I_CLR_EVENTS && I_DATA[EVT_A]))
				evf_a <= 1'b0;
			if (uf_b)
				evf_b <= 1'b1;
			else if (start_b || take_b
				|| (I_CLR_EVENTS && I_DATA[EVT_B]))
				evf_b <= 1'b0;
		end
	end

	// ****************************************************************
	// enables and interrupt gating
	// ****************************************************************
	always_ff @(posedge I_CLK)
	begin
		if (I_RST)
		begin
			ief_a <= FLAGS_RESET[EVT_A];
			ief_b <= FLAGS_RESET[EVT_B];
			hef_a <= FLAGS_RESET[EVT_A];
			hef_b <= FLAGS_RESET[EVT_B];
		end
		else
		begin
			if (I_WR_IRQ_ENABLE)
			begin
				ief_a <= I_DATA[EVT_A];
				ief_b <= I_DATA[EVT_B];
			end
			if (I_WR_HOLD_ENABLE)
			begin
				hef_a <= I_DATA[EVT_A];
				hef_b <= I_DATA[EVT_B];
			end
		end
	end

	// disable wins over enable when both arrive together
	always_ff @(posedge I_CLK)
	begin
		if (I_RST)
			irq_block <= 1'b0;
		else if (I_GLOBAL_DISABLE || take_a || take_b)
			irq_block <= 1'b1;
		else if (I_GLOBAL_ENABLE || I_WR_IRQ_ENABLE)
			irq_block <= 1'b0;
	end

	assign pend_a = evf_a && ief_a;
	assign pend_b = evf_b && ief_b;
	assign O_IRQ_REQ = !irq_block && (pend_a || pend_b);
	// timer a has the lower vector and so the higher priority
	assign take_a = I_IRQ_TAKE && O_IRQ_REQ && pend_a;
	assign take_b = I_IRQ_TAKE && O_IRQ_REQ && !pend_a && pend_b;
	assign O_IRQ_VECTOR = !O_IRQ_REQ ? VEC_NONE
		: (pend_a ? VEC_TIMER_A : VEC_TIMER_B);

	// ****************************************************************
	// hold mode
	// ****************************************************************
	assign release_hold = (evf_a && hef_a) || (evf_b && hef_b);

	always_comb
	begin
		next_hold_st = hold_st;
		unique case (hold_st)
			ST_RUN:
				if (I_HOLD_ENTER)
					next_hold_st = ST_HOLD;
			ST_HOLD:
				if (release_hold)
					next_hold_st = ST_RUN;
				else if (I_IRQ_TAKE && O_IRQ_REQ)
					next_hold_st = ST_SVC;
			ST_SVC:
				if (I_RETURN)
					next_hold_st = ST_HOLD;
			default:
				next_hold_st = ST_RUN;
		endcase
	end

	always_ff @(posedge I_CLK)
	begin
		if (I_RST)
			hold_st <= ST_RUN;
		else
			hold_st <= next_hold_st;
	end

	// ****************************************************************
	// outputs
	// ****************************************************************
	assign O_TIMER_A_COUNT = cnt_a;
	assign O_TIMER_B_COUNT = cnt_b;
	assign O_EVENT_FLAGS = {evf_b, 5'h00, evf_a, 1'b0};
	assign O_TIMER_A_RUN = run_a;
	assign O_TIMER_B_RUN = run_b;
	assign O_HOLD = (hold_st == ST_HOLD);
	assign O_TONE = tone_pin;

	// ****************************************************************
	// checks
	// ****************************************************************
	default clocking cb @(posedge I_CLK); endclocking
	default disable iff (I_RST);

	a_load_stops_a: assert property (wr_a_load |=> !run_a)
		else $error("timer a still running after load write");
	a_start_clears_a: assert property (start_a && !wr_a_load
		|=> run_a && !evf_a)
		else $error("timer a start did not clear flag");
	a_underflow_a: assert property (uf_a
		|=> !run_a && evf_a && cnt_a == 8'hff)
		else $error("timer a underflow wrong");
	a_decrement_a: assert property (run_a && tk.tick_a && !uf_a
		&& !wr_a_load && !I_WR_A_MODE |=> cnt_a == $past(cnt_a) - 8'h01)
		else $error("timer a did not decrement");
	a_fast_period: assert property (run_a && !sel_a && tk.tick_a
		&& !wr_a_load && !I_WR_A_MODE |=> !tk.tick_a [*3])
		else $error("timer a fast prescale not four");
	a_stopped_holds: assert property (!run_a && !wr_a_load
		|=> $stable(cnt_a))
		else $error("stopped timer a moved");
	a_load_stops_b: assert property (wr_b_load |=> !run_b)
		else $error("timer b still running after reload write");
	a_reload_b: assert property (uf_b
		|=> run_b && evf_b && cnt_b == $past(reload_b))
		else $error("timer b did not auto reload");
	a_start_b: assert property (start_b && !wr_b_load
		|=> cnt_b == $past(reload_b) && !evf_b)
		else $error("timer b start wrong");
	a_tone_toggle: assert property (uf_b |=> tone_q != $past(tone_q))
		else $error("tone did not toggle");
	a_irq_gating: assert property (O_IRQ_REQ
		|-> ((O_EVENT_FLAGS[EVT_A] && ief_a)
		|| (O_EVENT_FLAGS[EVT_B] && ief_b)) && !irq_block)
		else $error("interrupt without enabled flag");
	a_take_blocks: assert property (I_IRQ_TAKE && O_IRQ_REQ
		&& !I_WR_IRQ_ENABLE |=> !O_IRQ_REQ)
		else $error("interrupt not blocked after take");
	a_global_dis: assert property (I_GLOBAL_DISABLE
		|=> !O_IRQ_REQ)
		else $error("request after global disable");
	a_set_wins: assert property (uf_a && I_CLR_EVENTS && I_DATA[EVT_A]
		|=> evf_a)
		else $error("lost timer a event");
	a_hold_return: assert property (hold_st == ST_SVC && I_RETURN
		|=> O_HOLD)
		else $error("did not return to hold");

	c_underflow_a: cover property (uf_a);
	c_tone_b: cover property (uf_b && route_b);
	c_irq_in_hold: cover property (O_HOLD && I_IRQ_TAKE && O_IRQ_REQ);
	c_hold_release: cover property (O_HOLD && release_hold);
endmodule : dti_top
